// *** include/psp_ctl_params.svh ***
// constants for the processing state and privilege control block
`ifndef PSP_CTL_PARAMS_SVH
`define PSP_CTL_PARAMS_SVH

// reference class codes, line2 line1 line0
`define PSP_FC_UNASSIGNED   3'h0
`define PSP_FC_USER_DATA    3'h1
`define PSP_FC_USER_PROG    3'h2
`define PSP_FC_SUPER_DATA   3'h5
`define PSP_FC_SUPER_PROG   3'h6
`define PSP_FC_INT_ACK      3'h7

// privilege select bit after reset and saved copy after reset
`define PSP_S_RESET         1'h1
`define PSP_SAVED_S_RESET   1'h1

`endif

// *** include/psp_pkg.sv ***
// types shared by the processing state and privilege control block
package psp_pkg;

	// processing state; stopped is a sub-state of normal
	typedef enum logic [1:0] {
		PSP_NORMAL,
		PSP_STOPPED,
		PSP_EXCEPTION,
		PSP_HALTED
	} psp_state_t;

	// decoded class of the instruction offered for execution
	typedef enum logic [2:0] {
		PSP_INS_PLAIN,
		PSP_INS_STOP,
		PSP_INS_RESET,
		PSP_INS_WRITE_SR,
		PSP_INS_COPY_INTO_USER_STACK_PTR,
		PSP_INS_COPY_OUT_OF_USER_STACK_PTR
	} psp_ins_t;

endpackage

// *** include/psp_priv_if.sv ***
// privilege signals shared between the control core and its helpers
`timescale 1ns/1ps
`default_nettype none

interface psp_priv_if;
	logic                eff_super;
	psp_pkg::psp_ins_t   ins_class;
	logic                violation;
	logic                bus_prog;
	logic                bus_iack;
	logic [2:0]          fc;

	modport ctl (output eff_super, output ins_class, output bus_prog, output bus_iack,
		input violation, input fc);
	modport checker_side (input eff_super, input ins_class, output violation);
	modport encoder_side (input eff_super, input bus_prog, input bus_iack, output fc);
endinterface

`default_nettype wire

// *** rtl/psp_priv_check.sv ***
// privileged instruction checker
`timescale 1ns/1ps
`default_nettype none

module psp_priv_check (
	psp_priv_if.checker_side pif
);
	// supervisor may run everything; user is refused the system instructions
	always_comb begin
		pif.violation = 1'b0;
		if (!pif.eff_super) begin
			case (pif.ins_class)
				psp_pkg::PSP_INS_STOP:          pif.violation = 1'b1;
				psp_pkg::PSP_INS_RESET:         pif.violation = 1'b1;
				psp_pkg::PSP_INS_WRITE_SR:      pif.violation = 1'b1;
				psp_pkg::PSP_INS_COPY_INTO_USER_STACK_PTR:   pif.violation = 1'b1;
				psp_pkg::PSP_INS_COPY_OUT_OF_USER_STACK_PTR: pif.violation = 1'b1;
				default:                        pif.violation = 1'b0;
			endcase
		end
	end
endmodule

`default_nettype wire

// *** rtl/psp_ref_class.sv ***
// bus cycle reference class encoder
`timescale 1ns/1ps
`default_nettype none
`include "psp_ctl_params.svh"

module psp_ref_class (
	psp_priv_if.encoder_side pif
);
	// acknowledge wins over program or data; level picks the upper half
	function automatic logic [2:0] fc_encode(input logic sup, input logic prog, input logic iack);
		logic [2:0] code;
		code = `PSP_FC_UNASSIGNED;
		if (iack)
			code = `PSP_FC_INT_ACK;
		else if (sup)
			code = prog ? `PSP_FC_SUPER_PROG : `PSP_FC_SUPER_DATA;
		else
			code = prog ? `PSP_FC_USER_PROG : `PSP_FC_USER_DATA;
		return code;
	endfunction

	assign pif.fc = fc_encode(pif.eff_super, pif.bus_prog, pif.bus_iack);
endmodule

`default_nettype wire

// *** rtl/psp_ctl.sv ***
// processing state and privilege control core
//
// Function
// - always exactly one of normal, exception or halted processing
// - stop instruction enters stopped sub-state; no memory references there
// - exception entered on instruction, internal condition, interrupt, bus error, reset
// - bus error during bus error exception processing halts the device
// - halted device restarts only through external reset
// - stopped and halted never hold together
// - two privilege levels choose legal operations and stack pointer
// - privilege bit high during execution means supervisor
// - supervisor executes every instruction without privilege fault
// - supervisor instruction bus cycles are marked supervisor references
// - supervisor stack and address register seven use supervisor pointer
// - exception processing runs supervisor; its bus cycles marked supervisor
// - exception stack pushes and pops use supervisor pointer
// - privilege bit low during execution means user
// - user level refuses stop and reset instructions
// - user level refuses whole status register writes
// - user level refuses copies into and out of user stack pointer
// - user instruction bus cycles are marked user references
// - user stack and address register seven use user pointer
// - only exceptions raise privilege; entry saves then sets privilege bit
// - three reference class lines classify every bus cycle
// - privileged instruction at user level raises privilege violation exception
`timescale 1ns/1ps
`default_nettype none
`include "psp_ctl_params.svh"

module psp_ctl (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                instr_valid,
	input  wire psp_pkg::psp_ins_t   instr_class,
	input  wire logic                sr_write_s,
	input  wire logic                int_exc_req,
	input  wire logic                irq_req,
	input  wire logic                berr,
	input  wire logic                exc_done,
	input  wire logic                bus_req,
	input  wire logic                bus_prog,
	input  wire logic                bus_iack,
	output psp_pkg::psp_state_t      proc_state,
	output logic                     stopped,
	output logic                     halted,
	output logic                     supervisor,
	output logic                     s_bit,
	output logic                     saved_s,
	output logic                     bus_start,
	output logic                     reference_class_line0,
	output logic                     reference_class_line1,
	output logic                     reference_class_line2,
	output logic                     stack_ssp_sel,
	output logic                     stack_user_ptr_sel,
	output logic                     instr_exec,
	output logic                     priv_violation
);

	psp_pkg::psp_state_t state;
	psp_pkg::psp_state_t next_state;
	logic                next_s;
	logic                next_saved_s;
	logic                next_in_berr;
	logic                enter_exc;
	logic                in_berr;
	logic                eff_super;
	logic                next_super;
	logic                bus_ok;

	psp_priv_if pif ();

	// helpers see the level that applies right now
	assign pif.eff_super = eff_super;
	assign pif.ins_class = instr_class;
	assign pif.bus_prog  = bus_prog;
	assign pif.bus_iack  = bus_iack;

	psp_priv_check i_psp_priv_check (
		.pif (pif)
	);

	psp_ref_class i_psp_ref_class (
		.pif (pif)
	);

	// exception processing forces supervisor regardless of the bit
	assign eff_super = s_bit | (state == psp_pkg::PSP_EXCEPTION);

	// only normal and exception processing may reference memory
	assign bus_ok = (state == psp_pkg::PSP_NORMAL) || (state == psp_pkg::PSP_EXCEPTION);

	// next processing state; bus error outranks instruction events
	always_comb begin
		next_state   = state;
		enter_exc    = 1'b0;
		next_in_berr = in_berr;
		case (state)
			psp_pkg::PSP_NORMAL: begin
				if (berr) begin
					enter_exc    = 1'b1;
					next_in_berr = 1'b1;
				end else if (instr_valid && pif.violation) begin
					enter_exc    = 1'b1;
				end else if (int_exc_req || irq_req) begin
					enter_exc    = 1'b1;
				end else if (instr_valid && instr_class == psp_pkg::PSP_INS_STOP) begin
					next_state   = psp_pkg::PSP_STOPPED;
				end
			end
			psp_pkg::PSP_STOPPED: begin
				// no bus cycles here, so only an interrupt wakes it
				if (irq_req)
					enter_exc = 1'b1;
			end
			psp_pkg::PSP_EXCEPTION: begin
				if (berr && in_berr) begin
					next_state = psp_pkg::PSP_HALTED;
				end else if (berr) begin
					enter_exc    = 1'b1;
					next_in_berr = 1'b1;
				end else if (exc_done) begin
					next_state   = psp_pkg::PSP_NORMAL;
					next_in_berr = 1'b0;
				end
			end
			psp_pkg::PSP_HALTED: begin
				next_state = psp_pkg::PSP_HALTED;
			end
			default: begin
				next_state = psp_pkg::PSP_HALTED;
			end
		endcase
		if (enter_exc)
			next_state = psp_pkg::PSP_EXCEPTION;
	end

	// privilege bit: raised only by exception entry, lowered only by a
	// whole status register write that the supervisor is allowed to make
	always_comb begin
		next_s       = s_bit;
		next_saved_s = saved_s;
		if (enter_exc && state != psp_pkg::PSP_EXCEPTION) begin
			next_saved_s = s_bit;
			next_s       = 1'b1;
		end else if (state == psp_pkg::PSP_NORMAL && instr_valid && !pif.violation &&
			instr_class == psp_pkg::PSP_INS_WRITE_SR && !berr && !int_exc_req && !irq_req) begin
			next_s       = sr_write_s;
		end
	end

	assign next_super = next_s | (next_state == psp_pkg::PSP_EXCEPTION);

	// state register; reset lands in exception processing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= psp_pkg::PSP_EXCEPTION;
			in_berr <= 1'b0;
		end else begin
			state   <= next_state;
			in_berr <= next_in_berr;
		end
	end

	// privilege bit and its saved copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_bit   <= `PSP_S_RESET;
			saved_s <= `PSP_SAVED_S_RESET;
		end else begin
			s_bit   <= next_s;
			saved_s <= next_saved_s;
		end
	end

	// state flags mirror the next state so they line up with it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			proc_state <= psp_pkg::PSP_EXCEPTION;
			stopped    <= 1'b0;
			halted     <= 1'b0;
		end else begin
			proc_state <= next_state;
			stopped    <= (next_state == psp_pkg::PSP_STOPPED);
			halted     <= (next_state == psp_pkg::PSP_HALTED);
		end
	end

	// level and stack pointer choice, aligned with the state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			supervisor         <= 1'b1;
			stack_ssp_sel      <= 1'b1;
			stack_user_ptr_sel <= 1'b0;
		end else begin
			supervisor         <= next_super;
			stack_ssp_sel      <= next_super;
			stack_user_ptr_sel <= !next_super;
		end
	end

	// bus cycle launch and its class; the class is that of the level in force
	// when the request is taken, so a cycle never changes class midway
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_start             <= 1'b0;
			reference_class_line0 <= 1'b0;
			reference_class_line1 <= 1'b0;
			reference_class_line2 <= 1'b0;
		end else begin
			bus_start <= bus_req && bus_ok;
			if (bus_req && bus_ok) begin
				reference_class_line0 <= pif.fc[0];
				reference_class_line1 <= pif.fc[1];
				reference_class_line2 <= pif.fc[2];
			end
		end
	end

	// instruction outcome pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_exec     <= 1'b0;
			priv_violation <= 1'b0;
		end else begin
			instr_exec     <= (state == psp_pkg::PSP_NORMAL) && instr_valid && !berr &&
				!pif.violation;
			priv_violation <= (state == psp_pkg::PSP_NORMAL) && instr_valid && !berr &&
				pif.violation;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_user_priv_try;
		state == psp_pkg::PSP_NORMAL && !s_bit && instr_valid && !berr &&
			(instr_class == psp_pkg::PSP_INS_STOP || instr_class == psp_pkg::PSP_INS_RESET);
	endsequence

	sequence s_user_bus;
		bus_req && state == psp_pkg::PSP_NORMAL && !s_bit && !bus_iack;
	endsequence

	sequence s_double_berr;
		state == psp_pkg::PSP_EXCEPTION && in_berr && berr;
	endsequence

	a_halt_sticky: assert property (state == psp_pkg::PSP_HALTED |=> halted &&
		state == psp_pkg::PSP_HALTED)
		else $error("halted state left without reset");

	a_stop_halt_apart: assert property (!(stopped && halted) &&
		(stopped == (state == psp_pkg::PSP_STOPPED)))
		else $error("stopped and halted flags disagree with state");

	a_stopped_no_bus: assert property (state == psp_pkg::PSP_STOPPED |=> !bus_start)
		else $error("bus cycle launched while stopped");

	a_exc_super_level: assert property (state == psp_pkg::PSP_EXCEPTION |->
		supervisor && stack_ssp_sel && !stack_user_ptr_sel)
		else $error("exception processing not at supervisor level");

	a_user_fault: assert property (s_user_priv_try |=> priv_violation && !instr_exec &&
		state == psp_pkg::PSP_EXCEPTION && s_bit && !saved_s)
		else $error("user stop or reset instruction not refused");

	a_user_class: assert property (s_user_bus |=> bus_start &&
		!reference_class_line2 && (reference_class_line1 != reference_class_line0))
		else $error("user bus cycle not marked as user reference");

	a_double_berr: assert property (s_double_berr |=> halted ##1 halted)
		else $error("second bus error did not halt");

	a_entry_saves: assert property (enter_exc && state == psp_pkg::PSP_NORMAL |=>
		s_bit && saved_s == $past(s_bit) && state == psp_pkg::PSP_EXCEPTION)
		else $error("exception entry did not save and set privilege bit");

	a_s_rise_cause: assert property ($rose(s_bit) |->
		state == psp_pkg::PSP_EXCEPTION)
		else $error("privilege raised outside exception processing");

	// most remaining checks follow their cause through one edge, the level and stack ones hold in the same cycle; a slip of one
	// cycle in the state register would trip several of them at once
	sequence s_super_bus;
		bus_req && state == psp_pkg::PSP_NORMAL && s_bit && !bus_iack;
	endsequence

	sequence s_user_sys_write;
		state == psp_pkg::PSP_NORMAL && !s_bit && instr_valid && !berr &&
			(instr_class == psp_pkg::PSP_INS_WRITE_SR ||
			instr_class == psp_pkg::PSP_INS_COPY_INTO_USER_STACK_PTR ||
			instr_class == psp_pkg::PSP_INS_COPY_OUT_OF_USER_STACK_PTR);
	endsequence

	a_super_exec: assert property (s_bit && instr_valid && !berr &&
		state == psp_pkg::PSP_NORMAL |=> instr_exec && !priv_violation)
		else $error("supervisor instruction refused");

	a_super_class: assert property (s_super_bus |=> bus_start &&
		reference_class_line2 && (reference_class_line1 != reference_class_line0))
		else $error("supervisor bus cycle not marked as supervisor reference");

	a_exc_class: assert property (bus_req && state == psp_pkg::PSP_EXCEPTION |=>
		bus_start && reference_class_line2)
		else $error("exception bus cycle not marked as supervisor reference");

	a_level_bit: assert property (state == psp_pkg::PSP_NORMAL |->
		supervisor == s_bit)
		else $error("level does not follow privilege bit");

	a_user_stack: assert property (state == psp_pkg::PSP_NORMAL && !s_bit |->
		stack_user_ptr_sel && !stack_ssp_sel)
		else $error("user level not on user stack pointer");

	a_super_stack: assert property (state == psp_pkg::PSP_NORMAL && s_bit |->
		stack_ssp_sel && !stack_user_ptr_sel)
		else $error("supervisor level not on supervisor stack pointer");

	a_user_sys_write: assert property (s_user_sys_write |=> priv_violation &&
		!instr_exec && state == psp_pkg::PSP_EXCEPTION)
		else $error("user status or stack pointer copy not refused");

	a_stop_wait: assert property (state == psp_pkg::PSP_STOPPED && !irq_req |=>
		state == psp_pkg::PSP_STOPPED && stopped)
		else $error("stopped state left without interrupt");

	a_berr_entry: assert property (state == psp_pkg::PSP_NORMAL && berr |=>
		state == psp_pkg::PSP_EXCEPTION && in_berr && supervisor)
		else $error("bus error did not start exception processing");

	a_cause_entry: assert property ((int_exc_req || irq_req) &&
		state == psp_pkg::PSP_NORMAL |=> state == psp_pkg::PSP_EXCEPTION)
		else $error("interrupt or internal cause did not start exception processing");

	a_exc_return: assert property (state == psp_pkg::PSP_EXCEPTION && exc_done &&
		!berr |=> state == psp_pkg::PSP_NORMAL && !in_berr)
		else $error("exception processing did not return to normal");

	a_halt_no_bus: assert property (state == psp_pkg::PSP_HALTED |=>
		!bus_start)
		else $error("bus cycle launched while halted");

endmodule

`default_nettype wire

// *** tb/psp_mmu_model.sv ***
// memory management and bus control model at the far side of the control block
`timescale 1ns/1ps
`default_nettype none

module psp_mmu_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic bus_start,
	input  wire logic err_en,
	output logic      berr
);
	// a flagged cycle ends in bus error one clock after launch, others end cleanly
	// limitation: there is no slow answer here, because no later error timing exists
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			berr <= 1'b0;
		end else begin
			berr <= bus_start & err_en;
		end
	end
endmodule

`default_nettype wire

// *** tb/tb_psp_ctl.sv ***
// self-checking bench for the processing state and privilege control block
`timescale 1ns/1ps
`default_nettype none

module tb_psp_ctl;
	logic                clk, rst_n, instr_valid, sr_write_s, int_exc_req, irq_req;
	logic                berr, exc_done, bus_req, bus_prog, bus_iack, err_en;
	logic                stopped, halted, supervisor, s_bit, saved_s, bus_start;
	logic                rcl0, rcl1, rcl2, ssp_sel, user_sel, instr_exec, priv_violation;
	psp_pkg::psp_ins_t   instr_class;
	psp_pkg::psp_state_t proc_state;
	int                  miscompares, checks, cycles;

	psp_ctl i_psp_ctl (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
		.instr_class(instr_class), .sr_write_s(sr_write_s), .int_exc_req(int_exc_req),
		.irq_req(irq_req), .berr(berr), .exc_done(exc_done), .bus_req(bus_req),
		.bus_prog(bus_prog), .bus_iack(bus_iack), .proc_state(proc_state),
		.stopped(stopped), .halted(halted), .supervisor(supervisor), .s_bit(s_bit),
		.saved_s(saved_s), .bus_start(bus_start), .reference_class_line0(rcl0),
		.reference_class_line1(rcl1), .reference_class_line2(rcl2),
		.stack_ssp_sel(ssp_sel), .stack_user_ptr_sel(user_sel), .instr_exec(instr_exec),
		.priv_violation(priv_violation));

	psp_mmu_model i_psp_mmu_model (.clk(clk), .rst_n(rst_n), .bus_start(bus_start),
		.err_en(err_en), .berr(berr));

	// clock and time-zero values
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard, well above the hundred-odd cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cs(input psp_pkg::psp_state_t exp);
		check("proc_state", {1'b0, proc_state}, {1'b0, exp});
	endtask

	// one offer per task; outputs are looked at just after the sampling edge
	task automatic offer(input psp_pkg::psp_ins_t c, input logic s);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_class <= c;
		sr_write_s <= s;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic bus(input logic prog, input logic iack);
		@(posedge clk);
		bus_req <= 1'b1;
		bus_prog <= prog;
		bus_iack <= iack;
		@(posedge clk);
		bus_req <= 1'b0;
		#1;
	endtask

	// k: 0 exception done, 1 interrupt, 2 internal cause
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: exc_done <= 1'b1;
			1: irq_req <= 1'b1;
			default: int_exc_req <= 1'b1;
		endcase
		@(posedge clk);
		exc_done <= 1'b0;
		irq_req <= 1'b0;
		int_exc_req <= 1'b0;
		#1;
	endtask

	task automatic wait_state(input psp_pkg::psp_state_t s);
		for (int i = 0; i < 8 && proc_state !== s; i++) begin
			@(posedge clk);
			#1;
		end
		cs(s);
	endtask

	task automatic t_reset_entry();
		cs(psp_pkg::PSP_EXCEPTION);
		check("priv", {supervisor, s_bit, saved_s}, 3'h7);
		check("stack", {1'b0, ssp_sel, user_sel}, 3'h2);
		pulse(0);
		cs(psp_pkg::PSP_NORMAL);
		check("flags", {1'b0, stopped, halted}, 3'h0);
		$display("test reset_entry done");
	endtask

	task automatic t_super();
		for (int i = 0; i < 6; i++) begin
			if (i != 1) begin
				offer(psp_pkg::psp_ins_t'(i), 1'b1);
				check("exec", {1'b0, instr_exec, priv_violation}, 3'h2);
			end
		end
		check("stack", {supervisor, ssp_sel, user_sel}, 3'h6);
		bus(1'b0, 1'b0);
		check("class", {rcl2, rcl1, rcl0}, 3'h5);
		check("start", {2'h0, bus_start}, 3'h1);
		bus(1'b1, 1'b0);
		check("class", {rcl2, rcl1, rcl0}, 3'h6);
		bus(1'b0, 1'b1);
		check("class", {rcl2, rcl1, rcl0}, 3'h7);
		$display("test super done");
	endtask

	task automatic t_user();
		offer(psp_pkg::PSP_INS_WRITE_SR, 1'b0);
		check("user", {supervisor, s_bit, user_sel}, 3'h1);
		bus(1'b0, 1'b0);
		check("class", {rcl2, rcl1, rcl0}, 3'h1);
		check("start", {2'h0, bus_start}, 3'h1);
		bus(1'b1, 1'b0);
		check("class", {rcl2, rcl1, rcl0}, 3'h2);
		offer(psp_pkg::PSP_INS_PLAIN, 1'b0);
		check("exec", {1'b0, instr_exec, priv_violation}, 3'h2);
		$display("test user done");
	endtask

	// every privileged class refused at user level, then back to user
	task automatic t_user_priv();
		for (int i = 1; i < 6; i++) begin
			offer(psp_pkg::psp_ins_t'(i), 1'b1);
			check("viol", {1'b0, instr_exec, priv_violation}, 3'h1);
			cs(psp_pkg::PSP_EXCEPTION);
			check("entry", {supervisor, s_bit, saved_s}, 3'h6);
			check("stack", {1'b0, ssp_sel, user_sel}, 3'h2);
			bus(1'b1, 1'b0);
			check("class", {rcl2, rcl1, rcl0}, 3'h6);
			pulse(0);
			check("ret", {1'b0, supervisor, s_bit}, 3'h3);
			offer(psp_pkg::PSP_INS_WRITE_SR, 1'b0);
		end
		$display("test user_priv done");
	endtask

	// internal cause, stop and wake, then an interrupt taken from normal execution
	task automatic t_stop();
		pulse(2);
		cs(psp_pkg::PSP_EXCEPTION);
		check("entry", {supervisor, s_bit, saved_s}, 3'h6);
		pulse(0);
		offer(psp_pkg::PSP_INS_STOP, 1'b1);
		cs(psp_pkg::PSP_STOPPED);
		check("flags", {1'b0, stopped, halted}, 3'h2);
		bus(1'b0, 1'b0);
		check("start", {2'h0, bus_start}, 3'h0);
		pulse(1);
		cs(psp_pkg::PSP_EXCEPTION);
		check("flags", {1'b0, stopped, halted}, 3'h0);
		pulse(0);
		pulse(1);
		cs(psp_pkg::PSP_EXCEPTION);
		pulse(0);
		$display("test stop done");
	endtask

	task automatic t_halt();
		err_en <= 1'b1;
		bus(1'b0, 1'b0);
		wait_state(psp_pkg::PSP_EXCEPTION);
		bus(1'b0, 1'b0);
		wait_state(psp_pkg::PSP_HALTED);
		err_en <= 1'b0;
		check("flags", {1'b0, stopped, halted}, 3'h1);
		pulse(1);
		pulse(0);
		cs(psp_pkg::PSP_HALTED);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		cs(psp_pkg::PSP_EXCEPTION);
		check("priv", {supervisor, s_bit, halted}, 3'h6);
		pulse(0);
		cs(psp_pkg::PSP_NORMAL);
		$display("test halt done");
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		{rst_n, instr_valid, sr_write_s, int_exc_req, irq_req} = 5'h0;
		{exc_done, bus_req, bus_prog, bus_iack, err_en} = 5'h0;
		instr_class = psp_pkg::PSP_INS_PLAIN;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_reset_entry();
		t_super();
		t_user();
		t_user_priv();
		t_stop();
		t_halt();
		summarize();
	end
endmodule

`default_nettype wire
